// [inc/mltp_pkg.sv]
package mltp_pkg;

    // Object dictionary addressing
    localparam logic [15:0] MLTP_IDX_GAINS      = 16'h3210;
    localparam logic [15:0] MLTP_IDX_FLAGS      = 16'h3212;
    localparam logic [7:0]  MLTP_SUB_COUNT      = 8'h00;
    localparam logic [7:0]  MLTP_SUB_FIRST_GAIN = 8'h01;
    localparam logic [7:0]  MLTP_SUB_LAST_GAIN  = 8'h0C;
    localparam logic [7:0]  MLTP_SUB_FLUX_P     = 8'h05;
    localparam logic [7:0]  MLTP_SUB_RESERVED   = 8'h01;
    localparam logic [7:0]  MLTP_SUB_FIELD_OVR  = 8'h02;
    localparam logic [7:0]  MLTP_SUB_KEEP       = 8'h03;

    // Entry counts read back from subindex 00
    localparam logic [7:0]  MLTP_GAINS_COUNT    = 8'h0C;
    localparam logic [7:0]  MLTP_FLAGS_COUNT    = 8'h03;

    localparam int          MLTP_NUM_GAINS      = 12;
    localparam int          MLTP_NUM_LOADED     = 8;
    localparam logic [3:0]  MLTP_FIRST_LOADED   = 4'h4;

    // Reset values, element 0 is subindex 01
    localparam logic [11:0][31:0] MLTP_GAIN_RST = {
        32'h0000_0000,  // 0C acceleration feed forward, off
        32'h0000_03E8,  // 0B velocity feed forward, 1000 per mille
        32'h001D_2B30,  // 0A open loop integral
        32'h004D_C880,  // 09 open loop proportional
        32'h0007_C740,  // 08 torque integral
        32'h0088_1EE0,  // 07 torque proportional
        32'h0007_C740,  // 06 flux integral
        32'h0088_1EE0,  // 05 flux proportional
        32'h0000_001E,  // 04 velocity integral
        32'h0000_2EE0,  // 03 velocity proportional
        32'h0000_0000,  // 02 position integral
        32'h0000_0800   // 01 position proportional
    };

    // Preconfigured sets for subindex 05..0C; stepper set equals reset values
    localparam logic [7:0][31:0] MLTP_STEPPER_SET = MLTP_GAIN_RST[11:4];
    localparam logic [7:0][31:0] MLTP_BLDC_SET = {
        32'h0000_0000, 32'h0000_03E8, 32'h0010_0000, 32'h0020_0000,
        32'h0004_0000, 32'h0040_0000, 32'h0004_0000, 32'h0040_0000
    };

    localparam logic [7:0]  MLTP_FIELD_OVR_RST  = 8'h00;
    localparam logic [7:0]  MLTP_KEEP_RST       = 8'h00;
    localparam logic [7:0]  MLTP_DIR_POS        = 8'h01;
    localparam logic [7:0]  MLTP_DIR_NEG        = 8'hFF;
    localparam logic [15:0] MLTP_AUTOSETUP_CYC  = 16'h0010;
    localparam logic signed [63:0] MLTP_PER_MILLE = 64'sh0000_0000_0000_03E8;

    typedef enum logic [1:0] {
        MLTP_DIR_DEFAULT,
        MLTP_DIR_FORCE_POS,
        MLTP_DIR_FORCE_NEG
    } mltp_dir_t;

    typedef enum logic [1:0] {
        MLTP_AS_IDLE,
        MLTP_AS_RUN,
        MLTP_AS_FINISH
    } mltp_as_t;

    typedef struct packed {
        logic        req;
        logic        wr;
        logic [15:0] index;
        logic [7:0]  sub;
        logic [31:0] wdata;
    } mltp_od_req_t;

    typedef struct packed {
        logic        ack;
        logic        err;
        logic [31:0] rdata;
    } mltp_od_rsp_t;

    typedef struct packed {
        logic [31:0] flux_p;
        logic [31:0] flux_i;
        logic [31:0] torque_p;
        logic [31:0] torque_i;
        logic [31:0] open_p;
        logic [31:0] open_i;
    } mltp_gains_t;

    typedef struct packed {
        logic [11:0][31:0] gain;
        logic [7:0]        field_ovr;
        logic [7:0]        keep;
        mltp_dir_t         dir_active;
        mltp_as_t          as_state;
        logic [15:0]       as_cnt;
        logic              as_done;
        mltp_od_rsp_t      rsp;
        logic [31:0]       vff;
        logic [31:0]       aff;
    } mltp_state_t;

endpackage

// [logic/mltp_store.sv]
// Operation
// - Flux proportional gain, 32-bit read/write, resets to 00881EE0h.
// - Flux integral gain, 32-bit read/write, resets to 0007C740h.
// - Torque proportional gain, read/write, resets to same value as flux proportional.
// - Torque integral gain, 32-bit read/write, resets to 0007C740h.
// - Open loop proportional gain, read/write, resets to 004DC880h.
// - Open loop integral gain, read/write, resets to 001D2B30h.
// - Closed loop velocity feed forward scaled per mille, reset 1000 means unity.
// - Closed loop acceleration feed forward, zero disables, also acts while decelerating.
// - Field override: 0 default, 1 forces positive field, -1 forces negative.
// - New field override applies only at restart; host reruns auto setup afterwards.
// - Keep flag 0: auto setup loads set matching detected stepper or BLDC.
// - Keep flag 1: auto setup uses host gains and leaves them unchanged.
// - Position proportional gain, 32-bit read/write, resets to 00000800h.
// - Velocity proportional gain, 32-bit read/write, resets to 00002EE0h.
`timescale 1ns/1ps
`default_nettype none

module mltp_store
    import mltp_pkg::*;
(
    input  wire logic         mclk,
    input  wire logic         resetn,
    input  wire mltp_od_req_t od_req,
    output var  mltp_od_rsp_t od_rsp,
    input  wire logic         ctrl_restart,
    input  wire logic         autosetup_start,
    input  wire logic         motor_is_bldc,
    output logic              autosetup_busy,
    output logic              autosetup_done,
    input  wire logic         loop_closed,
    input  wire logic [31:0]  vel_ff_in,
    input  wire logic [31:0]  accel_ff_in,
    output logic [31:0]       vel_ff_out,
    output logic [31:0]       accel_ff_out,
    output var  mltp_gains_t  gains,
    output logic [31:0]       pos_prop_gain,
    output logic [31:0]       vel_prop_gain,
    output logic [31:0]       vel_int_gain,
    output var  mltp_dir_t    field_dir,
    output logic              keep_settings
);

    mltp_state_t state_reg;
    mltp_state_t state_next;

    localparam mltp_state_t STATE_RST = '{
        gain:       MLTP_GAIN_RST,
        field_ovr:  MLTP_FIELD_OVR_RST,
        keep:       MLTP_KEEP_RST,
        dir_active: MLTP_DIR_DEFAULT,
        as_state:   MLTP_AS_IDLE,
        as_cnt:     16'h0000,
        as_done:    1'b0,
        rsp:        '0,
        vff:        32'h0000_0000,
        aff:        32'h0000_0000
    };

    always_comb begin
        logic              is_gain_sub;
        logic [3:0]        gidx;
        logic signed [63:0] vprod;
        logic signed [63:0] aprod;
        logic [11:0][31:0] loaded;
        is_gain_sub = 1'b0;
        gidx        = 4'h0;
        vprod       = 64'sh0000_0000_0000_0000;
        aprod       = 64'sh0000_0000_0000_0000;
        loaded      = state_reg.gain;
        state_next  = state_reg;

        // Detected parameter set, applied only when the keep flag is clear
        loaded[11:4] = motor_is_bldc ? MLTP_BLDC_SET : MLTP_STEPPER_SET;

        // Object dictionary access, answered one cycle after the request
        state_next.rsp.ack   = od_req.req;
        state_next.rsp.err   = 1'b0;
        state_next.rsp.rdata = 32'h0000_0000;
        is_gain_sub = (od_req.sub >= MLTP_SUB_FIRST_GAIN) &&
                      (od_req.sub <= MLTP_SUB_LAST_GAIN);
        gidx = 4'(od_req.sub - MLTP_SUB_FIRST_GAIN);

        if (od_req.req) begin
            if (od_req.index == MLTP_IDX_GAINS) begin
                if (od_req.sub == MLTP_SUB_COUNT) begin
                    state_next.rsp.rdata = {24'h00_0000, MLTP_GAINS_COUNT};
                    state_next.rsp.err   = od_req.wr;
                end else if (is_gain_sub) begin
                    state_next.rsp.rdata = state_reg.gain[gidx];
                    if (od_req.wr) begin
                        state_next.gain[gidx] = od_req.wdata;
                    end
                end else begin
                    state_next.rsp.err = 1'b1;
                end
            end else if (od_req.index == MLTP_IDX_FLAGS) begin
                unique case (od_req.sub)
                    MLTP_SUB_COUNT: begin
                        state_next.rsp.rdata = {24'h00_0000, MLTP_FLAGS_COUNT};
                        state_next.rsp.err   = od_req.wr;
                    end
                    MLTP_SUB_RESERVED: begin
                        // Writes accepted and dropped; reads zero
                        state_next.rsp.rdata = 32'h0000_0000;
                    end
                    MLTP_SUB_FIELD_OVR: begin
                        state_next.rsp.rdata = {{24{state_reg.field_ovr[7]}},
                                                state_reg.field_ovr};
                        if (od_req.wr) begin
                            state_next.field_ovr = od_req.wdata[7:0];
                        end
                    end
                    MLTP_SUB_KEEP: begin
                        state_next.rsp.rdata = {{24{state_reg.keep[7]}}, state_reg.keep};
                        if (od_req.wr) begin
                            state_next.keep = od_req.wdata[7:0];
                        end
                    end
                    default: begin
                        state_next.rsp.err = 1'b1;
                    end
                endcase
            end else begin
                state_next.rsp.err = 1'b1;
            end
        end

        // Direction is only taken over at restart so a running field never flips
        if (ctrl_restart) begin
            if (state_reg.field_ovr == MLTP_DIR_POS) begin
                state_next.dir_active = MLTP_DIR_FORCE_POS;
            end else if (state_reg.field_ovr == MLTP_DIR_NEG) begin
                state_next.dir_active = MLTP_DIR_FORCE_NEG;
            end else begin
                // Out-of-range values fall back to the firmware default
                state_next.dir_active = MLTP_DIR_DEFAULT;
            end
        end

        // Auto setup sequence
        state_next.as_done = 1'b0;
        unique case (state_reg.as_state)
            MLTP_AS_IDLE: begin
                if (autosetup_start) begin
                    state_next.as_state = MLTP_AS_RUN;
                    state_next.as_cnt   = 16'h0000;
                end
            end
            MLTP_AS_RUN: begin
                state_next.as_cnt = 16'(state_reg.as_cnt + 16'h0001);
                if (state_reg.as_cnt == MLTP_AUTOSETUP_CYC - 16'h0001) begin
                    state_next.as_state = MLTP_AS_FINISH;
                end
            end
            MLTP_AS_FINISH: begin
                state_next.as_state = MLTP_AS_IDLE;
                state_next.as_done  = 1'b1;
                // Non-zero keep flag leaves stored gains as the host left them
                if (state_reg.keep == 8'h00) begin
                    // Loaded set wins over a host write in the same cycle; 01..04 stay open
                    state_next.gain[11:4] = loaded[11:4];
                end
            end
        endcase

        // Feed forward, closed loop only; the divide is costly but keeps per mille exact
        vprod = (64'(signed'(vel_ff_in)) * 64'(signed'(state_reg.gain[10]))) /
                MLTP_PER_MILLE;
        aprod = 64'(signed'(accel_ff_in)) * 64'(signed'(state_reg.gain[11]));
        state_next.vff = loop_closed ? vprod[31:0] : 32'h0000_0000;
        // Sign of the input carries deceleration through unchanged
        state_next.aff = (loop_closed && state_reg.gain[11] != 32'h0000_0000) ?
                         aprod[31:0] : 32'h0000_0000;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= STATE_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign od_rsp          = state_reg.rsp;
    assign autosetup_busy  = state_reg.as_state != MLTP_AS_IDLE;
    assign autosetup_done  = state_reg.as_done;
    assign vel_ff_out      = state_reg.vff;
    assign accel_ff_out    = state_reg.aff;
    assign pos_prop_gain   = state_reg.gain[0];
    assign vel_prop_gain   = state_reg.gain[2];
    assign vel_int_gain    = state_reg.gain[3];
    assign gains.flux_p    = state_reg.gain[4];
    assign gains.flux_i    = state_reg.gain[5];
    assign gains.torque_p  = state_reg.gain[6];
    assign gains.torque_i  = state_reg.gain[7];
    assign gains.open_p    = state_reg.gain[8];
    assign gains.open_i    = state_reg.gain[9];
    assign field_dir       = state_reg.dir_active;
    assign keep_settings   = state_reg.keep != 8'h00;

endmodule

`default_nettype wire

// [tb/mltp_store_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module mltp_store_chk
    import mltp_pkg::*;
(
    input wire logic         mclk,
    input wire logic         resetn,
    input wire mltp_od_req_t od_req,
    input wire mltp_od_rsp_t od_rsp,
    input wire logic         ctrl_restart,
    input wire logic         autosetup_start,
    input wire logic         autosetup_busy,
    input wire logic         autosetup_done,
    input wire logic         loop_closed,
    input wire logic [31:0]  vel_ff_out,
    input wire logic [31:0]  accel_ff_out,
    input wire mltp_gains_t  gains,
    input wire mltp_dir_t    field_dir,
    input wire logic         keep_settings
);
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (!resetn);
    property p_ack;
        od_req.req |=> od_rsp.ack;
    endproperty
    a_ack: assert property (p_ack) else $error("request not answered");
    property p_err;
        od_req.req && od_req.index != MLTP_IDX_GAINS && od_req.index != MLTP_IDX_FLAGS
            |=> od_rsp.ack && od_rsp.err;
    endproperty
    a_err: assert property (p_err) else $error("unknown index accepted");
    property p_hold;
        !$stable(gains) |->
            $past(od_req.req && od_req.wr && od_req.index == MLTP_IDX_GAINS) || autosetup_done;
    endproperty
    a_hold: assert property (p_hold) else $error("gains changed without cause");
    property p_keep;
        autosetup_done && keep_settings && !$past(od_req.req && od_req.wr) |-> $stable(gains);
    endproperty
    a_keep: assert property (p_keep) else $error("kept gains overwritten");
    property p_busy;
        autosetup_start && !autosetup_busy |=> autosetup_busy[*8];
    endproperty
    a_busy: assert property (p_busy) else $error("busy not held");
    property p_done;
        autosetup_start && !autosetup_busy |-> ##18 autosetup_done;
    endproperty
    a_done: assert property (p_done) else $error("done not on time");
    property p_dir;
        !ctrl_restart |=> $stable(field_dir);
    endproperty
    a_dir: assert property (p_dir) else $error("field direction moved early");
    property p_open;
        !loop_closed |=> vel_ff_out == 32'h0000_0000 && accel_ff_out == 32'h0000_0000;
    endproperty
    a_open: assert property (p_open) else $error("feed forward in open loop");
    c_done: cover property (autosetup_done);
    c_neg: cover property (ctrl_restart ##1 field_dir == MLTP_DIR_FORCE_NEG);
    c_err: cover property (od_rsp.ack && od_rsp.err);
endmodule
bind mltp_store mltp_store_chk chk (.mclk(mclk), .resetn(resetn), .od_req(od_req),
    .od_rsp(od_rsp), .ctrl_restart(ctrl_restart), .autosetup_start(autosetup_start),
    .autosetup_busy(autosetup_busy), .autosetup_done(autosetup_done),
    .loop_closed(loop_closed), .vel_ff_out(vel_ff_out), .accel_ff_out(accel_ff_out),
    .gains(gains), .field_dir(field_dir), .keep_settings(keep_settings));
`default_nettype wire

// [tb/mltp_store_test.sv]
`timescale 1ns/1ps
`default_nettype none
module mltp_store_test
    import mltp_pkg::*;
;
    logic         mclk = 1'b0;
    logic         resetn = 1'b0;
    mltp_od_req_t od_req = '0;
    mltp_od_rsp_t od_rsp;
    logic         restart = 1'b0;
    logic         start = 1'b0;
    logic         bldc = 1'b0;
    logic         busy;
    logic         done;
    logic         closed = 1'b0;
    logic [31:0]  vin = '0;
    logic [31:0]  ain = '0;
    logic [31:0]  vout;
    logic [31:0]  aout;
    mltp_gains_t  gains;
    logic [31:0]  pos_p;
    logic [31:0]  vel_p;
    logic [31:0]  vel_i;
    logic         keep_q;
    mltp_dir_t    dir;
    logic [31:0]  rd;
    int           fail_count = 0;
    int           n_tests = 0;
    always #2 mclk = ~mclk;
    mltp_store DUT (.mclk(mclk), .resetn(resetn), .od_req(od_req), .od_rsp(od_rsp),
        .ctrl_restart(restart), .autosetup_start(start), .motor_is_bldc(bldc),
        .autosetup_busy(busy), .autosetup_done(done), .loop_closed(closed),
        .vel_ff_in(vin), .accel_ff_in(ain), .vel_ff_out(vout), .accel_ff_out(aout),
        .gains(gains), .pos_prop_gain(pos_p), .vel_prop_gain(vel_p), .vel_int_gain(vel_i),
        .field_dir(dir), .keep_settings(keep_q));
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One access, then an idle cycle so req never toggles twice at one edge
    task automatic od(input logic w, input logic [15:0] i, input logic [7:0] s,
                      input logic [31:0] d, input logic e);
        od_req = '{1'b1, w, i, s, d};
        @(negedge mclk);
        od_req.req = 1'b0;
        check({31'h0, od_rsp.ack}, 32'h1);
        check({31'h0, od_rsp.err}, {31'h0, e});
        rd = od_rsp.rdata;
        @(negedge mclk);
    endtask
    task automatic rdchk(input logic [15:0] i, input logic [7:0] s, input logic [31:0] x);
        od(1'b0, i, s, 32'h0000_0000, 1'b0);
        check(rd, x);
    endtask
    task automatic t_reset();
        for (int s = 1; s <= 12; s++) begin
            rdchk(MLTP_IDX_GAINS, 8'(s), MLTP_GAIN_RST[s-1]);
        end
        check(gains.torque_p, 32'h0088_1EE0);
        check(gains.open_i, 32'h001D_2B30);
        check(pos_p, 32'h0000_0800);
        check(vel_p, 32'h0000_2EE0);
        check(vel_i, 32'h0000_001E);
        check({30'h0, dir}, {30'h0, MLTP_DIR_DEFAULT});
        check({31'h0, keep_q}, 32'h0000_0000);
        rdchk(MLTP_IDX_FLAGS, 8'h02, 32'h0000_0000);
    endtask
    task automatic t_rw();
        for (int s = 5; s <= 12; s++) begin
            od(1'b1, MLTP_IDX_GAINS, 8'(s), {24'hA5C3_96, 8'(s)}, 1'b0);
            rdchk(MLTP_IDX_GAINS, 8'(s), {24'hA5C3_96, 8'(s)});
        end
        check(gains.torque_i, 32'hA5C3_9608);
        od(1'b1, MLTP_IDX_GAINS, 8'h00, 32'h0000_0001, 1'b1);
        od(1'b0, 16'h3211, 8'h01, 32'h0000_0000, 1'b1);
        od(1'b0, MLTP_IDX_GAINS, 8'h0D, 32'h0000_0000, 1'b1);
        od(1'b0, MLTP_IDX_FLAGS, 8'h04, 32'h0000_0000, 1'b1);
        rdchk(MLTP_IDX_GAINS, 8'h00, 32'h0000_000C);
        rdchk(MLTP_IDX_FLAGS, 8'h00, 32'h0000_0003);
        // Reserved entry takes the write without storing it
        od(1'b1, MLTP_IDX_FLAGS, 8'h01, 32'h0000_005A, 1'b0);
        rdchk(MLTP_IDX_FLAGS, 8'h01, 32'h0000_0000);
    endtask
    task automatic t_dir();
        logic [7:0] v[4] = '{8'h01, 8'h05, 8'hFF, 8'h00};
        mltp_dir_t  x[4] = '{MLTP_DIR_FORCE_POS, MLTP_DIR_DEFAULT, MLTP_DIR_FORCE_NEG,
                             MLTP_DIR_DEFAULT};
        for (int k = 0; k < 4; k++) begin
            od(1'b1, MLTP_IDX_FLAGS, 8'h02, {24'h0000_00, v[k]}, 1'b0);
            check({30'h0, dir}, {30'h0, (k == 0) ? MLTP_DIR_DEFAULT : x[k-1]});
            restart = 1'b1;
            @(negedge mclk);
            restart = 1'b0;
            check({30'h0, dir}, {30'h0, x[k]});
            rdchk(MLTP_IDX_FLAGS, 8'h02, {{24{v[k][7]}}, v[k]});
        end
    endtask
    task automatic run_as(input logic keep, input logic kind);
        int i;
        od(1'b1, MLTP_IDX_FLAGS, 8'h03, {31'h0, keep}, 1'b0);
        check({31'h0, keep_q}, {31'h0, keep});
        bldc = kind;
        start = 1'b1;
        for (i = 1; i <= 30 && !done; i++) begin
            @(negedge mclk);
            start = 1'b0;
        end
        check(i - 1, 18);
        if (i > 30) summarize();
    endtask
    task automatic t_as();
        run_as(1'b0, 1'b1);
        check(gains.flux_p, 32'h0040_0000);
        check(gains.open_p, 32'h0020_0000);
        od(1'b1, MLTP_IDX_GAINS, 8'h05, 32'h0000_1234, 1'b0);
        run_as(1'b1, 1'b0);
        check(gains.flux_p, 32'h0000_1234);
        run_as(1'b0, 1'b0);
        check(gains.flux_p, 32'h0088_1EE0);
    endtask
    task automatic t_ff();
        closed = 1'b1;
        vin = 32'd2000;
        ain = -32'sd5;
        repeat (2) @(negedge mclk);
        check(vout, 32'd2000);
        check(aout, 32'h0000_0000);
        od(1'b1, MLTP_IDX_GAINS, 8'h0B, 32'd500, 1'b0);
        od(1'b1, MLTP_IDX_GAINS, 8'h0C, 32'd3, 1'b0);
        @(negedge mclk);
        check(vout, 32'd1000);
        check(aout, 32'hFFFF_FFF1);
        closed = 1'b0;
        repeat (2) @(negedge mclk);
        check(vout | aout, 32'h0000_0000);
    endtask
    initial begin
        repeat (12) @(negedge mclk);
        resetn = 1'b1;
        @(negedge mclk);
        t_reset();
        t_rw();
        t_dir();
        t_as();
        t_ff();
        // Mid-run reset must bring back every entry and flag
        od(1'b1, MLTP_IDX_FLAGS, 8'h03, 32'h0000_0001, 1'b0);
        resetn = 1'b0;
        repeat (2) @(negedge mclk);
        resetn = 1'b1;
        @(negedge mclk);
        t_reset();
        summarize();
    end
endmodule
`default_nettype wire
